/* File: rtl/udfh_byte_buf.sv */
`timescale 1ns/10ps
`default_nettype none
`include "udfh_defs.svh"
module udfh_byte_buf (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic clr,
   input wire logic wr,
   input wire logic [7:0] wdata,
   // drain side
   input wire logic [2:0] rd_idx,
   output logic [7:0] rdata,
   output logic [3:0] fill
);
   logic [7:0] mem_r [`UDFH_BUF_DEPTH];
   logic [3:0] wptr_r;
   logic room;

   // bytes past the eighth are dropped rather than wrapping over the first
   assign room = wptr_r < `UDFH_BUF_LIMIT;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_r <= 4'h0;
      end else if (clr) begin
         wptr_r <= 4'h0;
      end else if (wr && room) begin
         wptr_r <= wptr_r + 4'h1;
      end
   end

   // data storage has no reset, only the pointer does
   always_ff @(posedge clk) begin
      if (wr && room && !clr) begin
         mem_r[wptr_r[2:0]] <= wdata;
      end
   end

   assign rdata = mem_r[rd_idx];
   assign fill = wptr_r;
endmodule // udfh_byte_buf
`default_nettype wire

/* File: rtl/udfh_core.sv */
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "udfh_defs.svh"
module udfh_core (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial engine events
   input wire logic usb_reset,
   input wire logic tok_valid,
   input wire logic [1:0] tok_pid,
   input wire logic [1:0] tok_ep,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_done,
   input wire logic rx_toggle,
   input wire logic rx_err,
   input wire logic tx_ready,
   input wire logic host_ack,
   input wire logic host_timeout,
   // answers to serial engine
   output logic resp_valid,
   output logic [1:0] resp_code,
   output logic resp_toggle,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   output logic setup_event,
   output logic out_event
);
   localparam logic [7:0] TXDAT_IDX [0:2] = '{`UDFH_IDX_TXD0, `UDFH_IDX_TXD1, `UDFH_IDX_TXD2};
   localparam logic [7:0] TXCNT_IDX [0:2] = '{`UDFH_IDX_TXC0, `UDFH_IDX_TXC1, `UDFH_IDX_TXC2};
   localparam logic [7:0] TXFLG_IDX [0:2] = '{`UDFH_IDX_TXF0, `UDFH_IDX_TXF1, `UDFH_IDX_TXF2};

   udfh_pkg::udfh_state_t state_r;
   logic [2:0] tx_loaded_r, toggle_r, ep12_stall_r, ep12_enable_r;
   logic [3:0] tx_count_r [0:2];
   logic [7:0] tx_rdata [0:2];
   logic ep0_in_stall_r, ep0_out_stall_r, ep0_out_nak_force_r, ep0_rx_loaded_r;
   logic ep0_rx_toggle_r, ep0_setup_overwrite_r, ep0_receive_fault_r;
   logic valid_out_toggle_select_r, stall_arm_on_out_r, stall_arm_on_in_r;
   logic [3:0] rx_count_r, rx_fill, send_idx_r;
   logic [2:0] rx_rptr_r;
   logic [7:0] rx_rdata, rd_val;
   logic [1:0] cur_ep_r;
   logic cur_setup_r, accept_r, pready_r, known;
   logic setup_ph, acc, wr, rd, addr_ok;
   logic ack_ev, in0_ev, out0_ev, setup_ev, good_rx, arm_eff, rx_clr, tok_idle;
   logic [7:0] reg_idx;

   function automatic logic hit(input logic [7:0] idx);
      hit = addr_ok && (reg_idx == idx);
   endfunction

   assign setup_ph = psel && !penable;
   assign acc = psel && penable && pready_r;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign reg_idx = paddr[9:2];
   assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);

   assign tok_idle = tok_valid && (state_r == udfh_pkg::ST_IDLE);
   assign ack_ev = (state_r == udfh_pkg::ST_WAIT) && host_ack;
   assign in0_ev = ack_ev && (cur_ep_r == 2'h0);
   assign good_rx = (state_r == udfh_pkg::ST_RECV) && rx_done && !rx_err && accept_r;
   assign out0_ev = good_rx && !cur_setup_r;
   assign setup_ev = good_rx && cur_setup_r;
   // an OUT carrying DATA0 does not arm stalls when DATA1 only is selected
   assign arm_eff = stall_arm_on_out_r && (!valid_out_toggle_select_r || rx_toggle);
   assign rx_clr = tok_idle && (tok_ep == 2'h0) && (tok_pid == udfh_pkg::PID_SETUP
      || (tok_pid == udfh_pkg::PID_OUT && !ep0_out_stall_r && !ep0_out_nak_force_r && !ep0_rx_loaded_r));

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_tx
         udfh_byte_buf u_buf (
            .clk(pclk),
            .rst_n(presetn),
            .clr(wr && hit(TXFLG_IDX[g]) && pwdata[`UDFH_B_LOADED]),
            .wr(wr && hit(TXDAT_IDX[g])),
            .wdata(pwdata[7:0]),
            .rd_idx(send_idx_r[2:0]),
            .rdata(tx_rdata[g]),
            .fill()
         );
      end
   endgenerate

   udfh_byte_buf u_rx (
      .clk(pclk),
      .rst_n(presetn),
      .clr(rx_clr),
      .wr((state_r == udfh_pkg::ST_RECV) && rx_valid && accept_r),
      .wdata(rx_data),
      .rd_idx(rx_rptr_r),
      .rdata(rx_rdata),
      .fill(rx_fill)
   );

   // transmit flags, counts, toggles, ep1/ep2 stall and enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_loaded_r <= 3'h0;
         toggle_r <= 3'h0;
         ep12_stall_r <= 3'h0;
         ep12_enable_r <= 3'h0;
         for (int i = 0; i < 3; i++) tx_count_r[i] <= 4'h0;
      end else if (usb_reset) begin
         tx_loaded_r <= 3'h0;
         toggle_r <= 3'h0;
         ep12_stall_r <= 3'h0;
         ep12_enable_r <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (ack_ev && (cur_ep_r == 2'(i))) begin
               tx_loaded_r[i] <= 1'b0;
               toggle_r[i] <= !toggle_r[i];
            end
            if (wr && hit(TXCNT_IDX[i])) begin
               tx_count_r[i] <= pwdata[3:0];
            end
            // a firmware load in the ACK cycle wins: it is new data
            if (wr && hit(TXFLG_IDX[i])) begin
               tx_loaded_r[i] <= pwdata[`UDFH_B_LOADED];
               if (i > 0) begin
                  ep12_stall_r[i] <= pwdata[`UDFH_B_STALL];
                  ep12_enable_r[i] <= pwdata[`UDFH_B_ENABLE];
                  if (pwdata[`UDFH_B_SEQRST]) toggle_r[i] <= 1'b0;
               end
            end
         end
         // control data stage after SETUP starts at DATA1
         if (setup_ev) toggle_r[0] <= 1'b1;
      end
   end

   // ep0 stall bits; hardware updates land after firmware writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ep0_in_stall_r <= 1'b0;
         ep0_out_stall_r <= 1'b0;
      end else if (usb_reset) begin
         ep0_in_stall_r <= 1'b0;
         ep0_out_stall_r <= 1'b0;
      end else begin
         if (wr && hit(`UDFH_IDX_TXF0)) ep0_in_stall_r <= pwdata[`UDFH_B_STALL];
         if (wr && hit(`UDFH_IDX_RXF0)) ep0_out_stall_r <= pwdata[`UDFH_B_STALL];
         if (in0_ev) begin
            ep0_out_stall_r <= stall_arm_on_in_r && !stall_arm_on_out_r;
            if (stall_arm_on_in_r) ep0_in_stall_r <= 1'b1;
         end
         if (out0_ev) begin
            ep0_in_stall_r <= arm_eff && !stall_arm_on_in_r;
            if (arm_eff) ep0_out_stall_r <= 1'b1;
         end
      end
   end

   // ep0 receive flags; a hardware set beats a same-cycle clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ep0_rx_loaded_r <= 1'b0;
         ep0_receive_fault_r <= 1'b0;
         ep0_setup_overwrite_r <= 1'b0;
         ep0_rx_toggle_r <= 1'b0;
         ep0_out_nak_force_r <= 1'b0;
         rx_count_r <= 4'h0;
         rx_rptr_r <= 3'h0;
      end else if (usb_reset) begin
         ep0_rx_loaded_r <= 1'b0;
         ep0_receive_fault_r <= 1'b0;
         ep0_setup_overwrite_r <= 1'b0;
         ep0_rx_toggle_r <= 1'b0;
         ep0_out_nak_force_r <= 1'b0;
      end else begin
         if (wr && hit(`UDFH_IDX_RXF0)) begin
            ep0_out_nak_force_r <= pwdata[`UDFH_B_NAKF];
            if (!pwdata[`UDFH_B_FAULT]) ep0_receive_fault_r <= 1'b0;
            if (!pwdata[`UDFH_B_LOADED]) begin
               ep0_rx_loaded_r <= 1'b0;
               ep0_setup_overwrite_r <= 1'b0;
            end
         end
         if (rd && hit(`UDFH_IDX_RXD0)) rx_rptr_r <= rx_rptr_r + 3'h1;
         if ((state_r == udfh_pkg::ST_RECV) && rx_done && rx_err) begin
            ep0_receive_fault_r <= 1'b1;
         end
         if (tok_idle && (tok_ep == 2'h0) && (tok_pid == udfh_pkg::PID_SETUP) && ep0_rx_loaded_r) begin
            ep0_setup_overwrite_r <= 1'b1;
         end
         if (good_rx) begin
            ep0_rx_loaded_r <= 1'b1;
            ep0_rx_toggle_r <= rx_toggle;
            rx_count_r <= rx_fill;
            rx_rptr_r <= 3'h0;
         end
      end
   end

   // stall arming; a SETUP returns it to its idle value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_out_toggle_select_r <= 1'b0;
         stall_arm_on_out_r <= 1'b0;
         stall_arm_on_in_r <= 1'b0;
      end else if (usb_reset || setup_ev) begin
         valid_out_toggle_select_r <= 1'b0;
         stall_arm_on_out_r <= 1'b0;
         stall_arm_on_in_r <= 1'b0;
      end else if (wr && hit(`UDFH_IDX_CRW)) begin
         valid_out_toggle_select_r <= pwdata[`UDFH_B_TOGSEL];
         stall_arm_on_out_r <= pwdata[`UDFH_B_ARM_OUT];
         stall_arm_on_in_r <= pwdata[`UDFH_B_ARM_IN];
      end
   end

   // transaction sequencer and answers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= udfh_pkg::ST_IDLE;
         cur_ep_r <= 2'h0;
         cur_setup_r <= 1'b0;
         accept_r <= 1'b0;
         send_idx_r <= 4'h0;
         resp_valid <= 1'b0;
         resp_code <= 2'h0;
         resp_toggle <= 1'b0;
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
         tx_last <= 1'b0;
         setup_event <= 1'b0;
         out_event <= 1'b0;
      end else begin
         resp_valid <= 1'b0;
         tx_valid <= 1'b0;
         tx_last <= 1'b0;
         setup_event <= 1'b0;
         out_event <= 1'b0;
         if (usb_reset) begin
            state_r <= udfh_pkg::ST_IDLE;
         end else begin
            case (state_r)
               udfh_pkg::ST_IDLE: begin
                  if (tok_valid && (tok_pid == udfh_pkg::PID_IN) && (tok_ep != 2'h3)) begin
                     cur_ep_r <= tok_ep;
                     send_idx_r <= 4'h0;
                     if ((tok_ep == 2'h0) ? ep0_in_stall_r : ep12_stall_r[tok_ep]) begin
                        resp_valid <= 1'b1;
                        resp_code <= udfh_pkg::RESP_STALL;
                     end else if ((tok_ep != 2'h0) && !ep12_enable_r[tok_ep]) begin
                        resp_valid <= 1'b0;
                     end else if (tx_loaded_r[tok_ep]) begin
                        resp_valid <= 1'b1;
                        resp_code <= udfh_pkg::RESP_DATA;
                        resp_toggle <= toggle_r[tok_ep];
                        state_r <= (tx_count_r[tok_ep] == 4'h0) ? udfh_pkg::ST_WAIT : udfh_pkg::ST_SEND;
                     end else begin
                        resp_valid <= 1'b1;
                        resp_code <= udfh_pkg::RESP_NAK;
                     end
                  end else if (tok_valid && (tok_pid != udfh_pkg::PID_IN) && (tok_ep == 2'h0)) begin
                     cur_ep_r <= 2'h0;
                     cur_setup_r <= (tok_pid == udfh_pkg::PID_SETUP);
                     accept_r <= rx_clr;
                     state_r <= udfh_pkg::ST_RECV;
                  end
               end
               udfh_pkg::ST_SEND: begin
                  if (tx_ready) begin
                     tx_valid <= 1'b1;
                     tx_data <= tx_rdata[cur_ep_r];
                     send_idx_r <= send_idx_r + 4'h1;
                     if (send_idx_r + 4'h1 >= tx_count_r[cur_ep_r]) begin
                        tx_last <= 1'b1;
                        state_r <= udfh_pkg::ST_WAIT;
                     end
                  end
               end
               udfh_pkg::ST_WAIT: begin
                  // without an ACK the loaded flag is left alone for a retry
                  if (host_ack || host_timeout || tok_valid) begin
                     state_r <= udfh_pkg::ST_IDLE;
                  end
               end
               udfh_pkg::ST_RECV: begin
                  if (rx_done) begin
                     state_r <= udfh_pkg::ST_IDLE;
                     // errored data gets no handshake so the host retries
                     if (!rx_err) begin
                        resp_valid <= 1'b1;
                        if (!cur_setup_r && ep0_out_stall_r) begin
                           resp_code <= udfh_pkg::RESP_STALL;
                        end else if (!accept_r) begin
                           resp_code <= udfh_pkg::RESP_NAK;
                        end else begin
                           resp_code <= udfh_pkg::RESP_ACK;
                           setup_event <= cur_setup_r;
                           out_event <= !cur_setup_r;
                        end
                     end
                  end
               end
               default: state_r <= udfh_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // read mux; write-only data and count ports read as zero
   always_comb begin
      rd_val = 8'h00;
      known = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (hit(TXDAT_IDX[i]) || hit(TXCNT_IDX[i])) known = 1'b1;
         if (hit(TXFLG_IDX[i])) begin
            known = 1'b1;
            rd_val[`UDFH_B_LOADED] = tx_loaded_r[i];
            rd_val[`UDFH_B_STALL] = (i == 0) ? ep0_in_stall_r : ep12_stall_r[i];
            rd_val[`UDFH_B_ENABLE] = (i == 0) ? 1'b0 : ep12_enable_r[i];
         end
      end
      if (hit(`UDFH_IDX_RXD0)) begin
         known = 1'b1;
         rd_val = rx_rdata;
      end
      if (hit(`UDFH_IDX_RXC0)) begin
         known = 1'b1;
         rd_val = {4'h0, rx_count_r};
      end
      if (hit(`UDFH_IDX_RXF0)) begin
         known = 1'b1;
         rd_val = {2'h0, ep0_receive_fault_r, ep0_setup_overwrite_r, ep0_rx_toggle_r,
                   ep0_out_nak_force_r, ep0_out_stall_r, ep0_rx_loaded_r};
      end
      if (hit(`UDFH_IDX_CRW)) begin
         known = 1'b1;
         rd_val = {5'h00, valid_out_toggle_select_r, stall_arm_on_out_r, stall_arm_on_in_r};
      end
   end

   // every access takes exactly one access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready_r <= setup_ph;
         pslverr <= setup_ph && !known;
         if (setup_ph) prdata <= {24'h00_0000, rd_val};
      end
   end
   assign pready = pready_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_in_loaded(int e);
      tok_idle && !usb_reset && tok_pid == udfh_pkg::PID_IN && tok_ep == 2'(e)
         && tx_loaded_r[e] && !ep12_stall_r[e] && ep12_enable_r[e];
   endsequence
   sequence s_data_out;
      resp_valid && resp_code == udfh_pkg::RESP_DATA && state_r != udfh_pkg::ST_IDLE;
   endsequence

   AST_IN0_STALL: assert property (tok_idle && !usb_reset && tok_pid == udfh_pkg::PID_IN
      && tok_ep == 2'h0 && ep0_in_stall_r |=> resp_valid && resp_code == udfh_pkg::RESP_STALL)
      else $error("ep0 IN stall not answered");
   AST_ACK_EMPTIES: assert property (ack_ev && cur_ep_r == 2'h1 && !usb_reset
      && !(wr && hit(`UDFH_IDX_TXF1)) |=> !tx_loaded_r[1])
      else $error("ACK did not empty ep1 buffer");
   AST_NOACK_KEEPS: assert property (state_r == udfh_pkg::ST_WAIT && host_timeout && !host_ack
      && !wr && !usb_reset |=> $stable(tx_loaded_r))
      else $error("loaded flag lost without ACK");
   AST_DISABLED_SILENT: assert property (tok_idle && !usb_reset && tok_pid == udfh_pkg::PID_IN
      && tok_ep == 2'h1 && !ep12_enable_r[1] && !ep12_stall_r[1] |=> !resp_valid)
      else $error("disabled endpoint answered");
   AST_TOGGLE_FLIP: assert property (ack_ev && cur_ep_r == 2'h1 && !usb_reset && !wr
      |=> toggle_r[1] != $past(toggle_r[1]))
      else $error("ep1 toggle did not flip on ACK");
   AST_RESET_EMPTY: assert property (usb_reset |=> tx_loaded_r == 3'h0)
      else $error("buffers not empty after reset");
   AST_SEND_STREAM: assert property (s_in_loaded(1) ##0 tx_count_r[1] != 4'h0
      |=> s_data_out ##0 state_r == udfh_pkg::ST_SEND)
      else $error("loaded buffer not streamed");
   AST_FAULT_SET: assert property (state_r == udfh_pkg::ST_RECV && rx_done && rx_err
      && !usb_reset |=> ep0_receive_fault_r && !resp_valid)
      else $error("receive error not flagged");
   AST_OVERWRITE: assert property (tok_idle && !usb_reset && tok_pid == udfh_pkg::PID_SETUP
      && tok_ep == 2'h0 && ep0_rx_loaded_r |=> ep0_setup_overwrite_r)
      else $error("SETUP overwrite not flagged");
   AST_LOADED_AFTER_ACK: assert property (good_rx && !usb_reset
      |=> ep0_rx_loaded_r && resp_valid && (setup_event || out_event))
      else $error("receive not completed in order");
   AST_ARM_OUT: assert property (out0_ev && arm_eff && !stall_arm_on_in_r && !usb_reset
      |=> ep0_in_stall_r && ep0_out_stall_r)
      else $error("OUT stall arm did not set stalls");
endmodule // udfh_core
`default_nettype wire

/* File: rtl/udfh_defs.svh */
// Summary of operation
// - ep0 IN stall bit forces STALL answer
// - firmware sets loaded flag, host ACK clears
// - no ACK keeps loaded flag for resend
// - disabled ep1/ep2 ignore IN tokens silently unless their stall bit is set
// - ep1/ep2 toggle flips on ACK, resettable
// - ep1/ep2 stall bit forces STALL answer
// - resets empty every transmit buffer flag
// - loaded buffer streams bytes, then awaits handshake
// - ep0 CRC or stuff error sets fault
// - SETUP over loaded buffer sets overwrite
// - ep0 receive toggle tracks SETUP/OUT data
// - OUT accepted only when empty, unforced
// - ep0 OUT stall bit forces STALL answer
// - good receive sets ep0 loaded flag
// - receive, ACK, event, store, then flag
// - toggle select narrows valid OUT to DATA1
// - OUT stall arm sets both ep0 stalls; with IN arm also set, OUT stall is set and IN stall cleared
// - IN stall arm sets both ep0 stalls; with OUT arm also set, IN stall is set and OUT stall cleared
// - unarmed valid tokens clear opposite stall
`ifndef UDFH_DEFS_SVH
`define UDFH_DEFS_SVH
`define UDFH_IDX_TXD1 8'hE2
`define UDFH_IDX_TXC1 8'hE3
`define UDFH_IDX_TXF1 8'hE4
`define UDFH_IDX_TXD2 8'hE5
`define UDFH_IDX_TXC2 8'hE6
`define UDFH_IDX_TXF2 8'hE7
`define UDFH_IDX_CRW 8'hE9
`define UDFH_IDX_TXD0 8'hEA
`define UDFH_IDX_TXC0 8'hEB
`define UDFH_IDX_TXF0 8'hEC
`define UDFH_IDX_RXD0 8'hED
`define UDFH_IDX_RXC0 8'hEE
`define UDFH_IDX_RXF0 8'hEF
`define UDFH_B_LOADED 0
`define UDFH_B_STALL 1
`define UDFH_B_SEQRST 2
`define UDFH_B_ENABLE 3
`define UDFH_B_NAKF 2
`define UDFH_B_RXTOG 3
`define UDFH_B_OVW 4
`define UDFH_B_FAULT 5
`define UDFH_B_ARM_IN 0
`define UDFH_B_ARM_OUT 1
`define UDFH_B_TOGSEL 2
`define UDFH_BUF_DEPTH 8
`define UDFH_BUF_LIMIT 4'h8
`endif

/* File: rtl/udfh_pkg.sv */
`default_nettype none
package udfh_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT, ST_RECV} udfh_state_t;
   typedef enum logic [1:0] {RESP_ACK, RESP_NAK, RESP_STALL, RESP_DATA} udfh_resp_t;
   typedef enum logic [1:0] {PID_OUT, PID_IN, PID_SETUP} udfh_pid_t;
endpackage
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: %h expected %h", $time, (a), (b)); end end
module tb;
   localparam logic [11:0] a_d1 = 12'h388, a_c1 = 12'h38C, a_f1 = 12'h390, a_f2 = 12'h39C, a_crw = 12'h3A4;
   localparam logic [11:0] a_f0 = 12'h3B0, a_rd = 12'h3B4, a_rc = 12'h3B8, a_rx = 12'h3BC;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, rerr, usb_reset, tok_valid, rx_valid, rx_done, rx_toggle, rx_err;
   logic tx_ready, host_ack, host_timeout, resp_valid, resp_toggle, tx_valid, tx_last, setup_event, out_event;
   logic [1:0] tok_pid, tok_ep, resp_code;
   logic [7:0] rx_data, tx_data;
   int mismatches = 0, n_compared = 0, cyc = 0, n0 = 0, nev = 0;
   udfh_core dut (.*);
   udfh_host_model p (.*);
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (out_event === 1'h1 || setup_event === 1'h1) nev++;
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic close_out();
      if (mismatches == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, 24'h0, d};
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      rerr = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'h1, a, d);
   endtask
   task automatic rg(input logic [11:0] a);
      xfer(1'h0, a, 8'h00);
   endtask
   task automatic tok(input logic [1:0] pid, input logic [1:0] ep);
      n0 = p.nr;
      p.pulse_tok(pid, ep);
      repeat (3) @(posedge pclk);
   endtask
   task automatic out(input logic [1:0] pid, input int n, input logic t, input logic e);
      n0 = p.nr;
      p.pulse_tok(pid, 2'h0);
      p.send_data(n, t, e);
      repeat (3) @(posedge pclk);
   endtask
   task automatic get_in(input logic ok);
      int t;
      t = p.nl;
      p.q.delete();
      tok(2'h1, 2'h1);
      for (int i = 0; i < 40 && p.nl == t; i++) @(posedge pclk);
      p.handshake(ok);
   endtask
   // loads always run with no other bus traffic in flight
   task automatic load1(input int n);
      for (int i = 0; i < n; i++) wr(a_d1, 8'h11 + 8'(i));
      wr(a_c1, 8'(n));
      wr(a_f1, 8'h09);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      rg(a_f1);
      `CHK(rd, 32'h0)
      rg(a_f2);
      `CHK(rd, 32'h0)
      rg(a_f0);
      `CHK(rd, 32'h0)
      rg(12'h000);
      `CHK(rerr, 1'h1)
      tok(2'h1, 2'h1);
      `CHK(p.nr, n0)
      wr(a_f1, 8'h08);
      tok(2'h1, 2'h1);
      `CHK(p.code, udfh_pkg::RESP_NAK)
      wr(a_f1, 8'h0A);
      tok(2'h1, 2'h1);
      `CHK(p.code, udfh_pkg::RESP_STALL)
      p.slow = 1'h1;
      load1(2);
      get_in(1'h0);
      `CHK(p.code, udfh_pkg::RESP_DATA)
      `CHK(p.q[1], 8'h12)
      `CHK(p.tog, 1'h0)
      rg(a_f1);
      `CHK(rd, 32'h9)
      get_in(1'h1);
      `CHK(p.tog, 1'h0)
      rg(a_f1);
      `CHK(rd, 32'h8)
      // toggle stands at one here, so the reset is visible
      wr(a_f1, 8'h0C);
      rg(a_f1);
      `CHK(rd, 32'h8)
      load1(1);
      get_in(1'h1);
      `CHK(p.tog, 1'h0)
      load1(0);
      get_in(1'h1);
      `CHK(p.tog, 1'h1)
      load1(1);
      p.bus_reset();
      rg(a_f1);
      `CHK(rd, 32'h0)
      wr(a_f0, 8'h02);
      tok(2'h1, 2'h0);
      `CHK(p.code, udfh_pkg::RESP_STALL)
      out(2'h0, 2, 1'h1, 1'h0);
      `CHK(p.code, udfh_pkg::RESP_ACK)
      `CHK(nev, 1)
      rg(a_rx);
      `CHK(rd, 32'h9)
      rg(a_rc);
      `CHK(rd, 32'h2)
      rg(a_rd);
      `CHK(rd, 32'h20)
      rg(a_f0);
      `CHK(rd, 32'h0)
      out(2'h0, 1, 1'h0, 1'h0);
      `CHK(p.code, udfh_pkg::RESP_NAK)
      out(2'h2, 1, 1'h0, 1'h0);
      rg(a_rx);
      `CHK(rd & 32'h11, 32'h11)
      wr(a_rx, 8'h00);
      out(2'h0, 1, 1'h0, 1'h1);
      `CHK(p.nr, n0)
      rg(a_rx);
      `CHK(rd & 32'h21, 32'h20)
      wr(a_rx, 8'h00);
      rg(a_rx);
      `CHK(rd & 32'h21, 32'h0)
      wr(a_rx, 8'h04);
      out(2'h0, 1, 1'h0, 1'h0);
      `CHK(p.code, udfh_pkg::RESP_NAK)
      wr(a_rx, 8'h02);
      out(2'h0, 1, 1'h0, 1'h0);
      `CHK(p.code, udfh_pkg::RESP_STALL)
      wr(a_rx, 8'h00);
      wr(a_crw, 8'h06);
      out(2'h0, 1, 1'h0, 1'h0);
      rg(a_rx);
      `CHK(rd & 32'h2, 32'h0)
      wr(a_rx, 8'h00);
      out(2'h0, 1, 1'h1, 1'h0);
      rg(a_rx);
      `CHK(rd & 32'h3, 32'h3)
      rg(a_f0);
      `CHK(rd & 32'h2, 32'h2)
      wr(a_rx, 8'h00);
      wr(a_crw, 8'h01);
      wr(a_f0, 8'h01);
      tok(2'h1, 2'h0);
      `CHK(p.code, udfh_pkg::RESP_DATA)
      p.handshake(1'h1);
      rg(a_rx);
      `CHK(rd & 32'h2, 32'h2)
      rg(a_f0);
      `CHK(rd, 32'h2)
      close_out();
   end
endmodule // tb
`default_nettype wire

/* File: test/udfh_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module udfh_host_model (
   // clock
   input wire logic pclk,
   // toward the block
   output logic usb_reset,
   output logic tok_valid,
   output logic [1:0] tok_pid,
   output logic [1:0] tok_ep,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_done,
   output logic rx_toggle,
   output logic rx_err,
   output logic tx_ready,
   output logic host_ack,
   output logic host_timeout,
   // from the block
   input wire logic resp_valid,
   input wire logic [1:0] resp_code,
   input wire logic resp_toggle,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last
);
   int nr = 0;
   int nl = 0;
   logic [1:0] code = 2'h0;
   logic tog = 1'h0;
   logic slow = 1'h0;
   logic [7:0] q[$];
   initial begin
      {usb_reset, tok_valid, tok_pid, tok_ep, rx_valid, rx_done, rx_toggle, rx_err, host_ack, host_timeout} = '0;
      rx_data = 8'h5A;
      tx_ready = 1'h1;
   end
   // a slow engine takes a byte only every other cycle
   always @(posedge pclk) begin
      tx_ready <= slow ? ~tx_ready : 1'h1;
      if (resp_valid === 1'h1) begin
         nr++;
         code = resp_code;
         tog = resp_toggle;
      end
      if (tx_valid === 1'h1) begin
         q.push_back(tx_data);
         if (tx_last === 1'h1) nl++;
      end
   end
   task automatic pulse_tok(input logic [1:0] pid, input logic [1:0] ep);
      @(posedge pclk);
      {tok_valid, tok_pid, tok_ep} <= {1'h1, pid, ep};
      @(posedge pclk);
      tok_valid <= 1'h0;
   endtask
   // released data line shows the inverse of its last byte
   task automatic send_data(input int n, input logic t, input logic e);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         {rx_valid, rx_data} <= {1'h1, 8'h20 + 8'(i)};
      end
      @(posedge pclk);
      {rx_valid, rx_done, rx_toggle, rx_err, rx_data} <= {1'h0, 1'h1, t, e, ~rx_data};
      @(posedge pclk);
      rx_done <= 1'h0;
   endtask
   task automatic handshake(input logic ok);
      @(posedge pclk);
      {host_ack, host_timeout} <= {ok, ~ok};
      @(posedge pclk);
      {host_ack, host_timeout} <= 2'h0;
   endtask
   task automatic bus_reset();
      @(posedge pclk);
      usb_reset <= 1'h1;
      @(posedge pclk);
      usb_reset <= 1'h0;
   endtask
endmodule // udfh_host_model
`default_nettype wire
